// >>> pmrs_pkg.sv
package pmrs_pkg;

    // ************************************************************
    // Power modes
    // ************************************************************
    typedef enum logic [3:0] {
        PMRS_ACTIVE     = 4'h1,
        PMRS_IDLE       = 4'h2,
        PMRS_SLEEP      = 4'h4,
        PMRS_DEEP_SLEEP = 4'h8
    } pmrs_mode_e;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] PMRS_ADDR_CTRL      = 4'h0;
    localparam logic [3:0] PMRS_ADDR_IDLE_TO   = 4'h4;
    localparam logic [3:0] PMRS_ADDR_SLEEP_TO  = 4'h8;
    localparam logic [3:0] PMRS_ADDR_DEEP_TO   = 4'hC;
    localparam logic [3:0] PMRS_ADDR_STATUS    = 4'h1;
    localparam logic [3:0] PMRS_ADDR_WAKE_TO   = 4'h2;

    localparam int PMRS_CTRL_REG_EN_BIT   = 0;
    localparam int PMRS_CTRL_FORCE_BIT    = 1;
    localparam int PMRS_CTRL_LP_CONN_BIT  = 2;

    localparam logic [2:0]  PMRS_CTRL_RESET     = 3'h1;
    localparam logic [15:0] PMRS_TIMEOUT_RESET  = 16'h0100;
    localparam logic [15:0] PMRS_WAKE_TO_RESET  = 16'h0400;

    localparam int PMRS_SYNC_STAGES = 2;

    // ************************************************************
    // Grouped signals
    // ************************************************************
    typedef struct packed {
        logic tx_pd;
        logic rx_pd;
        logic pll_pd;
        logic pa_pd;
    } pmrs_rf_pd_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } pmrs_bus_s;

endpackage

// >>> pmrs_sequencer.sv
// Behaviour
// - Four modes: active, idle, sleep, deep sleep.
// - Inactivity timeout steps one mode lower.
// - Activity returns straight to active.
// - Deep sleep disables core regulator output.
// - Always-on logic wakes chip on events.
// - Regulator disable gated by firmware enable.
// - Separate TX, RX, PLL, PA power-downs.
// - Radio powered only during packet windows.
// - Low-power connection uses LPO, timed wake.
// - Requests from registers and packet handling.
// - External reset forces power-on state.
// - Unconnected reset pin reads deasserted.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module pmrs_sequencer #(
    parameter int TIMER_W = 16
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               clk_en,
    input  wire logic               external_reset_n,
    input  wire logic               external_reset_n_connected,
    input  wire logic               user_activity,
    input  wire logic               pkt_tx_req,
    input  wire logic               pkt_rx_req,
    input  wire logic               pkt_sleep_req,
    input  wire pmrs_pkg::pmrs_bus_s bus,
    output logic [15:0]             rdata,
    output pmrs_pkg::pmrs_mode_e    power_mode,
    output logic                    core_regulator_output,
    output logic                    lpo_select,
    output pmrs_pkg::pmrs_rf_pd_s   rf_pd,
    output logic                    sys_reset_n
);
    import pmrs_pkg::*;

    // ************************************************************
    // Reset synchroniser
    // ************************************************************
    logic [PMRS_SYNC_STAGES-1:0] rst_sync_reg;
    logic                        ext_rst_pin;
    logic                        rst_n;

    // Pull-up model: an unconnected pin behaves as released
    assign ext_rst_pin = external_reset_n | ~external_reset_n_connected;

    // Assert at once, release only after two clean clocks
    always_ff @(posedge clk) begin
        if (!reset_n || !ext_rst_pin) begin
            rst_sync_reg <= '0;
        end else if (clk_en) begin
            rst_sync_reg <= {rst_sync_reg[PMRS_SYNC_STAGES-2:0], 1'b1};
        end
    end
    // Entry is combinational so no edge is lost while the pin is low
    assign rst_n = rst_sync_reg[PMRS_SYNC_STAGES-1] & reset_n & ext_rst_pin;

    always_ff @(posedge clk) begin
        if (!reset_n || !ext_rst_pin) begin
            sys_reset_n <= 1'b0;
        end else if (clk_en) begin
            sys_reset_n <= rst_sync_reg[PMRS_SYNC_STAGES-1];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [2:0]         ctrl_reg;
    logic [TIMER_W-1:0] idle_to_reg;
    logic [TIMER_W-1:0] sleep_to_reg;
    logic [TIMER_W-1:0] deep_to_reg;
    logic [TIMER_W-1:0] wake_to_reg;
    logic               force_pulse;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg     <= PMRS_CTRL_RESET;
            idle_to_reg  <= TIMER_W'(PMRS_TIMEOUT_RESET);
            sleep_to_reg <= TIMER_W'(PMRS_TIMEOUT_RESET);
            deep_to_reg  <= TIMER_W'(PMRS_TIMEOUT_RESET);
            wake_to_reg  <= TIMER_W'(PMRS_WAKE_TO_RESET);
        end else if (clk_en && bus.wr) begin
            unique case (bus.addr)
                PMRS_ADDR_CTRL:     ctrl_reg     <= bus.wdata[2:0];
                PMRS_ADDR_IDLE_TO:  idle_to_reg  <= bus.wdata[TIMER_W-1:0];
                PMRS_ADDR_SLEEP_TO: sleep_to_reg <= bus.wdata[TIMER_W-1:0];
                PMRS_ADDR_DEEP_TO:  deep_to_reg  <= bus.wdata[TIMER_W-1:0];
                PMRS_ADDR_WAKE_TO:  wake_to_reg  <= bus.wdata[TIMER_W-1:0];
                default: ;
            endcase
        end
    end
    // Force bit acts as a write-one trigger; its copy in ctrl_reg is unused and reads back as zero
    assign force_pulse = clk_en & bus.wr & (bus.addr == PMRS_ADDR_CTRL) & bus.wdata[PMRS_CTRL_FORCE_BIT];

    // ************************************************************
    // Mode sequencer
    // ************************************************************
    pmrs_mode_e         mode_reg;
    pmrs_mode_e         mode_next;
    logic [TIMER_W-1:0] idle_cnt_reg;
    logic [TIMER_W-1:0] limit;
    logic               timeout;
    logic               step_down;
    logic               wake_timer_hit;
    logic [TIMER_W-1:0] wake_cnt_reg;
    logic               lp_conn;

    assign lp_conn = ctrl_reg[PMRS_CTRL_LP_CONN_BIT];

    always_comb begin
        // Deep sleep has no lower mode, so its limit is never used
        limit = '1;
        unique case (mode_reg)
            PMRS_ACTIVE:     limit = idle_to_reg;
            PMRS_IDLE:       limit = sleep_to_reg;
            PMRS_SLEEP:      limit = deep_to_reg;
            PMRS_DEEP_SLEEP: limit = '1;
        endcase
    end

    assign timeout   = (idle_cnt_reg >= limit) && (mode_reg != PMRS_DEEP_SLEEP);
    assign step_down = timeout | force_pulse | pkt_sleep_req;
    assign wake_timer_hit = lp_conn && (mode_reg != PMRS_ACTIVE) && (wake_cnt_reg >= wake_to_reg);

    always_comb begin
        mode_next = mode_reg;
        if (user_activity || wake_timer_hit || pkt_tx_req || pkt_rx_req) begin
            mode_next = PMRS_ACTIVE;
        end else if (step_down) begin
            unique case (mode_reg)
                PMRS_ACTIVE:     mode_next = PMRS_IDLE;
                PMRS_IDLE:       mode_next = PMRS_SLEEP;
                PMRS_SLEEP:      mode_next = PMRS_DEEP_SLEEP;
                PMRS_DEEP_SLEEP: mode_next = PMRS_DEEP_SLEEP;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= PMRS_ACTIVE;
        end else if (clk_en) begin
            mode_reg <= mode_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idle_cnt_reg <= '0;
        end else if (clk_en) begin
            if (user_activity || (mode_next != mode_reg)) begin
                idle_cnt_reg <= '0;
            end else if (idle_cnt_reg != '1) begin
                idle_cnt_reg <= idle_cnt_reg + 1'b1;
            end
        end
    end

    // Wake timer runs only while parked in a low mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_cnt_reg <= '0;
        end else if (clk_en) begin
            if (mode_next == PMRS_ACTIVE || !lp_conn) begin
                wake_cnt_reg <= '0;
            end else if (wake_cnt_reg != '1) begin
                wake_cnt_reg <= wake_cnt_reg + 1'b1;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            power_mode            <= PMRS_ACTIVE;
            core_regulator_output <= 1'b1;
            lpo_select            <= 1'b0;
        end else if (clk_en) begin
            power_mode <= mode_next;
            // Firmware may keep the regulator on even in deep sleep
            core_regulator_output <= !((mode_next == PMRS_DEEP_SLEEP) && ctrl_reg[PMRS_CTRL_REG_EN_BIT]);
            lpo_select <= lp_conn && (mode_next != PMRS_ACTIVE);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rf_pd <= '{tx_pd: 1'b1, rx_pd: 1'b1, pll_pd: 1'b1, pa_pd: 1'b1};
        end else if (clk_en) begin
            rf_pd.tx_pd  <= !pkt_tx_req;
            rf_pd.pa_pd  <= !pkt_tx_req;
            rf_pd.rx_pd  <= !pkt_rx_req;
            rf_pd.pll_pd <= !(pkt_tx_req || pkt_rx_req);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (clk_en && bus.rd) begin
            unique case (bus.addr)
                PMRS_ADDR_CTRL:     rdata <= {13'h0, ctrl_reg & 3'h5};
                PMRS_ADDR_IDLE_TO:  rdata <= 16'(idle_to_reg);
                PMRS_ADDR_SLEEP_TO: rdata <= 16'(sleep_to_reg);
                PMRS_ADDR_DEEP_TO:  rdata <= 16'(deep_to_reg);
                PMRS_ADDR_WAKE_TO:  rdata <= 16'(wake_to_reg);
                PMRS_ADDR_STATUS:   rdata <= {10'h0, lpo_select, core_regulator_output, mode_reg};
                default:            rdata <= 16'h0000;
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_wake;
        @(posedge clk) disable iff (!rst_n) (clk_en && user_activity) |=> (power_mode == PMRS_ACTIVE);
    endproperty
    a_wake: assert property (p_wake) else $error("activity did not wake");

    property p_deep_reg;
        @(posedge clk) disable iff (!rst_n)
            (power_mode == PMRS_DEEP_SLEEP && ctrl_reg[0] && $stable(ctrl_reg)) |-> !core_regulator_output;
    endproperty
    a_deep_reg: assert property (p_deep_reg) else $error("regulator on in deep sleep");

    property p_step;
        @(posedge clk) disable iff (!rst_n)
            ($changed(power_mode) && power_mode != PMRS_ACTIVE) |-> (power_mode == ($past(power_mode) << 1));
    endproperty
    a_step: assert property (p_step) else $error("skipped a mode");

    property p_cnt_clr;
        @(posedge clk) disable iff (!rst_n) (clk_en && user_activity) |=> (idle_cnt_reg == 0);
    endproperty
    a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");

    property p_rf;
        @(posedge clk) disable iff (!rst_n) (clk_en && !pkt_tx_req && !pkt_rx_req) |=> rf_pd.pll_pd;
    endproperty
    a_rf: assert property (p_rf) else $error("pll left on");

    property p_rst;
        @(posedge clk) (!ext_rst_pin) |=> !sys_reset_n;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not applied");

    property p_sync;
        @(posedge clk) disable iff (!reset_n) $rose(ext_rst_pin) |=> !sys_reset_n;
    endproperty
    a_sync: assert property (p_sync) else $error("reset released unsynchronised");

    property p_lpo;
        @(posedge clk) disable iff (!rst_n) (power_mode == PMRS_ACTIVE) |-> !lpo_select;
    endproperty
    a_lpo: assert property (p_lpo) else $error("lpo in active");

    property p_lpo_on;
        @(posedge clk) disable iff (!rst_n)
            ($past(clk_en) && lp_conn && $stable(ctrl_reg) && power_mode != PMRS_ACTIVE) |-> lpo_select;
    endproperty
    a_lpo_on: assert property (p_lpo_on) else $error("lpo not selected in low mode");

    property p_deep_wake;
        @(posedge clk) disable iff (!rst_n)
            (clk_en && power_mode == PMRS_DEEP_SLEEP && user_activity) |=> core_regulator_output;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("regulator not restored on wake");

    property p_cnt_trans;
        @(posedge clk) disable iff (!rst_n)
            $changed(power_mode) |-> (idle_cnt_reg == '0);
    endproperty
    a_cnt_trans: assert property (p_cnt_trans) else $error("counter not cleared on transition");

    property p_rf_tx;
        @(posedge clk) disable iff (!rst_n)
            (clk_en && pkt_tx_req) |=> (!rf_pd.tx_pd && !rf_pd.pa_pd && !rf_pd.pll_pd);
    endproperty
    a_rf_tx: assert property (p_rf_tx) else $error("transmit path left powered down");

    property p_pkt_wake;
        @(posedge clk) disable iff (!rst_n)
            (clk_en && (pkt_tx_req || pkt_rx_req)) |=> (power_mode == PMRS_ACTIVE);
    endproperty
    a_pkt_wake: assert property (p_pkt_wake) else $error("packet request did not wake");

    property p_regen;
        @(posedge clk) disable iff (!rst_n)
            ($past(clk_en) && !ctrl_reg[PMRS_CTRL_REG_EN_BIT] && $stable(ctrl_reg)) |-> core_regulator_output;
    endproperty
    a_regen: assert property (p_regen) else $error("regulator off while firmware keeps it");

    // Leaving reset costs two synchroniser edges plus the output flop
    sequence s_pin_up;
        ext_rst_pin && clk_en;
    endsequence

    property p_release;
        @(posedge clk) disable iff (!reset_n)
            ($rose(ext_rst_pin) && clk_en) ##1 s_pin_up [*2] |=> sys_reset_n;
    endproperty
    a_release: assert property (p_release) else $error("reset release too slow");

endmodule

// >>> pmrs_host_model.sv
`timescale 1ns/1ps
// ************************************************************
// Host side of the external reset pin
// ************************************************************
// Holds the pin low for a scaled power-on time, then releases it;
// the bench may pull it low again later through pulse_rst.
module pmrs_host_model #(
    parameter int HOLD_CYC = 12
) (
    input  wire logic clk,
    input  wire logic pulse_rst,
    output logic      external_reset_n
);
    int   n       = 0;
    logic rel_reg = 1'b0;

    assign external_reset_n = rel_reg;

    always @(posedge clk) begin
        if (n < HOLD_CYC) begin
            n <= n + 1;
        end
        rel_reg <= (n >= HOLD_CYC) && !pulse_rst;
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pmrs_pkg::*;

    typedef struct {logic [3:0] a; logic [15:0] e;} pmrs_row_s;

    logic        clk       = 1'b0;
    logic        reset_n   = 1'b0;
    logic        conn      = 1'b1;
    logic        act       = 1'b0;
    logic        tx_req    = 1'b0;
    logic        rx_req    = 1'b0;
    logic        slp_req   = 1'b0;
    logic        pulse_rst = 1'b0;
    logic        en        = 1'b1;
    logic        ext_n;
    pmrs_bus_s   bus       = '0;
    logic [15:0] rdata;
    logic [15:0] d;
    pmrs_mode_e  power_mode;
    logic        regul;
    logic        lpo;
    logic        sys_n;
    pmrs_rf_pd_s rf_pd;
    int          err_total   = 0;
    int          check_count = 0;
    int          i;
    pmrs_row_s   rows[7] = '{'{PMRS_ADDR_CTRL, 16'h0001}, '{PMRS_ADDR_STATUS, 16'h0011},
        '{PMRS_ADDR_IDLE_TO, 16'h0100}, '{PMRS_ADDR_SLEEP_TO, 16'h0100},
        '{PMRS_ADDR_DEEP_TO, 16'h0100}, '{PMRS_ADDR_WAKE_TO, 16'h0400}, '{4'h3, 16'h0000}};

    initial forever #20 clk = ~clk;

    pmrs_host_model i_pmrs_host_model (.clk(clk), .pulse_rst(pulse_rst), .external_reset_n(ext_n));

    pmrs_sequencer i_pmrs_sequencer (
        .clk(clk), .reset_n(reset_n), .clk_en(en), .external_reset_n(ext_n),
        .external_reset_n_connected(conn), .user_activity(act), .pkt_tx_req(tx_req),
        .pkt_rx_req(rx_req), .pkt_sleep_req(slp_req), .bus(bus), .rdata(rdata),
        .power_mode(power_mode), .core_regulator_output(regul), .lpo_select(lpo),
        .rf_pd(rf_pd), .sys_reset_n(sys_n));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        tick(1);
        bus <= '0;
        tick(1);
    endtask

    task automatic rd(input logic [3:0] a);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        tick(1);
        d = rdata;
        bus <= '0;
        tick(1);
    endtask

    task automatic set_to(input logic [15:0] v);
        wr(PMRS_ADDR_IDLE_TO, v);
        wr(PMRS_ADDR_SLEEP_TO, v);
        wr(PMRS_ADDR_DEEP_TO, v);
    endtask

    // Bounded wait; running out of cycles ends the run
    task automatic wait_mode(input pmrs_mode_e m, input int lim);
        for (int k = 0; k < lim && power_mode !== m; k++) tick(1);
        chk(power_mode, m);
        if (power_mode !== m) conclude();
    endtask

    task automatic pulse_act;
        act <= 1'b1;
        tick(1);
        act <= 1'b0;
    endtask

    task automatic pulse_slp;
        slp_req <= 1'b1;
        tick(1);
        slp_req <= 1'b0;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        tick(10);
        reset_n <= 1'b1;
        for (i = 0; i < 40 && sys_n !== 1'b1; i++) tick(1);
        chk(sys_n, 1'b1);
        if (sys_n !== 1'b1) conclude();
        tick(2);
        chk({regul, lpo, rf_pd, power_mode}, {1'b1, 1'b0, 4'hF, PMRS_ACTIVE});
        foreach (rows[r]) begin
            rd(rows[r].a);
            chk(d, rows[r].e);
        end
        $display("Test registers done");

        set_to(16'h0008);
        wait_mode(PMRS_IDLE, 20);
        wait_mode(PMRS_SLEEP, 20);
        wait_mode(PMRS_DEEP_SLEEP, 20);
        tick(1);
        chk(regul, 1'b0);
        rd(PMRS_ADDR_STATUS);
        chk(d, 16'h0008);
        pulse_act();
        wait_mode(PMRS_ACTIVE, 2);
        tick(1);
        chk(regul, 1'b1);
        $display("Test step down and wake done");

        // Activity every 6 cycles keeps an 8-cycle timeout from expiring
        for (i = 0; i < 6; i++) begin
            pulse_act();
            tick(5);
            chk(power_mode, PMRS_ACTIVE);
        end
        wr(PMRS_ADDR_CTRL, 16'h0000);
        wait_mode(PMRS_DEEP_SLEEP, 40);
        tick(1);
        chk(regul, 1'b1);
        pulse_act();
        wait_mode(PMRS_ACTIVE, 2);
        wr(PMRS_ADDR_CTRL, 16'h0001);
        $display("Test counter restart and regulator enable done");

        set_to(16'h7FFF);
        pulse_slp();
        wait_mode(PMRS_IDLE, 3);
        wr(PMRS_ADDR_CTRL, 16'h0003);
        wait_mode(PMRS_SLEEP, 3);
        pulse_act();
        wait_mode(PMRS_ACTIVE, 2);
        for (i = 0; i < 2; i++) begin
            tx_req <= (i == 0);
            rx_req <= (i == 1);
            tick(3);
            chk(rf_pd, (i == 0) ? 4'h4 : 4'h9);
            tx_req <= 1'b0;
            rx_req <= 1'b0;
            tick(3);
            chk(rf_pd, 4'hF);
        end
        $display("Test requests and radio done");

        wr(PMRS_ADDR_WAKE_TO, 16'h0010);
        wr(PMRS_ADDR_CTRL, 16'h0005);
        pulse_slp();
        wait_mode(PMRS_IDLE, 3);
        tick(1);
        chk(lpo, 1'b1);
        wait_mode(PMRS_ACTIVE, 40);
        en <= 1'b0;
        pulse_slp();
        tick(2);
        chk(power_mode, PMRS_ACTIVE);
        en <= 1'b1;
        $display("Test timed wake done");

        conn <= 1'b0;
        pulse_rst <= 1'b1;
        tick(4);
        chk({sys_n, power_mode}, {1'b1, PMRS_ACTIVE});
        pulse_rst <= 1'b0;
        tick(2);
        conn <= 1'b1;
        pulse_slp();
        wait_mode(PMRS_IDLE, 3);
        pulse_rst <= 1'b1;
        tick(3);
        chk({sys_n, rf_pd, power_mode}, {1'b0, 4'hF, PMRS_ACTIVE});
        pulse_rst <= 1'b0;
        tick(2);
        chk(sys_n, 1'b0);
        for (i = 0; i < 3 && sys_n !== 1'b1; i++) tick(1);
        chk(sys_n, 1'b1);
        rd(PMRS_ADDR_IDLE_TO);
        chk(d, 16'h0100);
        $display("Test external reset done");
        conclude();
    end
endmodule
